/* design/hsf_top.sv */
module hsf_top
  import hsf_pkg::*;
#(
  parameter int         WAKE_CYC     = WAKE_CYCLES,
  parameter int         TMO_STEP_CYC = TMO_STEP_CYCLES,
  parameter int         SAMPLE_CYC   = SAMPLE_CYCLES,
  parameter int         DEPTH        = QUEUE_DEPTH,
  parameter logic [3:0] CHIP_ID      = 4'h3 // arbitrary value
)
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic [7:0]      dac_code,
  output logic            power_stage_enable,
  output logic            analog_source_select,
  output logic [1:0]      amp_gain
);

  ////////////////////////////////////////////////////////////////////////////
  // serial bus edge detection

  logic scl_q;
  logic sda_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end

  // data moving while clock is high marks framing, otherwise it is a bit
  wire bus_start = scl & scl_q & sda_q & ~sda_in;
  wire bus_stop  = scl & scl_q & ~sda_q & sda_in;
  wire scl_rise  = scl & ~scl_q;
  wire scl_fall  = ~scl & scl_q;

  ////////////////////////////////////////////////////////////////////////////
  // byte engine

  hsf_bus_t   bus_phase;
  hsf_bit_t   bit_phase;
  logic [2:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] rd_shift;
  logic [7:0] reg_ptr;
  logic       drive_low;
  logic       pending_ack;
  logic       dir_read;
  logic       master_nak;
  hsf_bus_t   next_bus_phase;

  logic       q_full;
  logic       q_empty;
  logic [7:0] q_data;
  logic       mux;
  logic [1:0] gain;
  logic       standby;
  logic [1:0] tmo_sel;
  logic       force_on;
  logic       soft_rst;
  hsf_play_t  play_state;

  wire [7:0] byte_now  = {shift[6:0], sda_in};
  wire       byte_done = scl_rise & (bit_phase == BIT_DATA) & (bit_cnt == LAST_BIT);
  wire       ptr_queue = (reg_ptr == REG_SAMPLE);
  wire       addr_hit  = (byte_now[7:1] == SLAVE_ADDR);
  wire       wr_strobe = byte_done & (bus_phase == BUS_WRITE);

  // refuse a queue byte only when the queue has no room
  wire byte_ack = (bus_phase == BUS_DEV)   ? addr_hit :
                  (bus_phase == BUS_REG)   ? 1'b1 :
                  (bus_phase == BUS_WRITE) ? ~(ptr_queue & q_full) :
                  1'b0;

  // status, control and power register read back
  wire [7:0] stat_val = {6'h00, q_empty, q_full};
  wire [7:0] ctrl_val = {1'b0, CHIP_ID, mux, gain};
  wire [7:0] pwr_val  = {1'b0, standby, 2'h0, tmo_sel, force_on, 1'b0};
  wire [7:0] rd_value = (reg_ptr == REG_STATUS) ? stat_val :
                        (reg_ptr == REG_CTRL)   ? ctrl_val :
                        (reg_ptr == REG_POWER)  ? pwr_val :
                        READ_ZERO;
  // queue address holds still so a long write keeps feeding samples
  wire [7:0] ptr_step = ptr_queue ? reg_ptr : reg_ptr + 8'h01;

  always_comb
  begin
    case (bus_phase)
      BUS_DEV:   next_bus_phase = ~pending_ack ? BUS_IDLE : (dir_read ? BUS_READ : BUS_REG);
      BUS_REG:   next_bus_phase = BUS_WRITE;
      BUS_WRITE: next_bus_phase = BUS_WRITE;
      BUS_READ:  next_bus_phase = master_nak ? BUS_IDLE : BUS_READ;
      default:   next_bus_phase = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bus_phase   <= BUS_IDLE;
      bit_phase   <= BIT_DATA;
      bit_cnt     <= 3'h0;
      shift       <= 8'h00;
      rd_shift    <= 8'h00;
      reg_ptr     <= 8'h00;
      drive_low   <= 1'b0;
      pending_ack <= 1'b0;
      dir_read    <= 1'b0;
      master_nak  <= 1'b0;
    end
    else if (bus_start)
    begin
      bus_phase <= BUS_DEV;
      bit_phase <= BIT_DATA;
      bit_cnt   <= 3'h0;
      drive_low <= 1'b0;
    end
    else if (bus_stop)
    begin
      bus_phase <= BUS_IDLE;
      bit_phase <= BIT_DATA;
      bit_cnt   <= 3'h0;
      drive_low <= 1'b0;
    end
    else if (bus_phase != BUS_IDLE)
    begin
      case (bit_phase)
        BIT_DATA:
        begin
          if (scl_rise)
          begin
            shift   <= byte_now;
            bit_cnt <= bit_cnt + 3'h1;
          end
          else if (scl_fall && bus_phase == BUS_READ && bit_cnt != 3'h0)
          begin
            drive_low <= ~rd_shift[BYTE_MSB];
            rd_shift  <= {rd_shift[6:0], 1'b0};
          end
          if (byte_done)
          begin
            bit_phase   <= BIT_ACK_SETUP;
            pending_ack <= byte_ack;
            if (bus_phase == BUS_DEV)
              dir_read <= byte_now[0];
            if (bus_phase == BUS_REG)
              reg_ptr <= byte_now;
            if (bus_phase == BUS_WRITE)
              reg_ptr <= ptr_step;
          end
        end
        BIT_ACK_SETUP:
        begin
          if (scl_fall)
          begin
            // hold data low for the whole ninth clock when accepting
            drive_low <= (bus_phase != BUS_READ) & pending_ack;
            bit_phase <= BIT_ACK;
          end
        end
        default:
        begin
          if (scl_rise)
            master_nak <= sda_in;
          if (scl_fall)
          begin
            bit_phase <= BIT_DATA;
            bit_cnt   <= 3'h0;
            bus_phase <= next_bus_phase;
            if (next_bus_phase == BUS_READ)
            begin
              drive_low <= ~rd_value[BYTE_MSB];
              rd_shift  <= {rd_value[6:0], 1'b0};
              reg_ptr   <= ptr_step;
            end
            else
              drive_low <= 1'b0;
          end
        end
      endcase
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = drive_low;

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  wire wr_ctrl  = wr_strobe & (reg_ptr == REG_CTRL);
  wire wr_power = wr_strobe & (reg_ptr == REG_POWER);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mux      <= MUX_RST;
      gain     <= GAIN_RST;
      standby  <= STBY_RST;
      tmo_sel  <= TMO_RST;
      force_on <= FORCE_RST;
      soft_rst <= 1'b0;
    end
    else if (soft_rst)
    begin
      mux      <= MUX_RST;
      gain     <= GAIN_RST;
      standby  <= STBY_RST;
      tmo_sel  <= TMO_RST;
      force_on <= FORCE_RST;
      soft_rst <= 1'b0;
    end
    else
    begin
      soft_rst <= wr_power & byte_now[PWR_RST_BIT];
      if (wr_ctrl)
      begin
        mux  <= byte_now[CTRL_MUX_BIT];
        gain <= byte_now[CTRL_GAIN_LSB +: 2];
      end
      if (wr_power)
      begin
        standby  <= byte_now[PWR_STBY_BIT];
        tmo_sel  <= byte_now[PWR_TMO_LSB +: 2];
        force_on <= byte_now[PWR_FORCE_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample queue and playback

  logic [31:0] tick_cnt;
  logic [31:0] wait_cnt;
  logic        force_ready;

  // a ramp in progress or standby swallows queue bytes
  wire discard   = (play_state == PLAY_RAMP) | standby;
  wire q_push    = wr_strobe & ptr_queue & ~q_full & ~discard;
  wire tick      = (tick_cnt == 32'(SAMPLE_CYC - 1));
  wire playing   = (play_state == PLAY_RUN) | (play_state == PLAY_WAIT);
  wire q_pop     = tick & ~q_empty & playing;
  wire wake_done = (wait_cnt == 32'(WAKE_CYC - 1));
  wire [31:0] tmo_cycles = 32'(({30'h0, tmo_sel} + 32'h1) * 32'(TMO_STEP_CYC));
  wire tmo_done  = (wait_cnt == tmo_cycles - 32'h1);
  // signed step toward the middle code
  wire [7:0] ramp_next = dac_code[BYTE_MSB] ? dac_code + RAMP_STEP : dac_code - RAMP_STEP;

  hsf_sample_queue #(
    .WIDTH (SAMPLE_W),
    .DEPTH (DEPTH)
  ) u_queue (
    .clk       (clk),
    .rst       (rst),
    .flush     (soft_rst),
    .push      (q_push),
    .push_data (byte_now),
    .pop       (q_pop),
    .full      (q_full),
    .empty     (q_empty),
    .pop_data  (q_data)
  );

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tick_cnt <= 32'h0;
    else if (tick)
      tick_cnt <= 32'h0;
    else
      tick_cnt <= tick_cnt + 32'h1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      play_state  <= PLAY_IDLE;
      dac_code    <= MID_SCALE;
      wait_cnt    <= 32'h0;
      force_ready <= 1'b0;
    end
    else if (soft_rst | standby)
    begin
      play_state  <= PLAY_IDLE;
      dac_code    <= MID_SCALE;
      wait_cnt    <= 32'h0;
      force_ready <= 1'b0;
    end
    else
    begin
      if (!force_on)
        force_ready <= 1'b0;
      case (play_state)
        PLAY_IDLE:
        begin
          wait_cnt <= 32'h0;
          if (q_push)
            play_state <= force_ready ? PLAY_RUN : PLAY_WAKE;
          else if (force_on & ~force_ready)
            play_state <= PLAY_WAKE;
        end
        PLAY_WAKE:
        begin
          if (wake_done)
          begin
            play_state  <= PLAY_RUN;
            force_ready <= force_on;
            wait_cnt    <= 32'h0;
          end
          else
            wait_cnt <= wait_cnt + 32'h1;
        end
        PLAY_RUN:
        begin
          if (q_pop)
            dac_code <= q_data;
          else if (tick)
          begin
            play_state <= PLAY_WAIT;
            wait_cnt   <= 32'h0;
          end
        end
        PLAY_WAIT:
        begin
          if (q_pop)
          begin
            dac_code   <= q_data;
            play_state <= PLAY_RUN;
          end
          else if (tmo_done)
            play_state <= (dac_code == MID_SCALE) ? PLAY_IDLE : PLAY_RAMP;
          else
            wait_cnt <= wait_cnt + 32'h1;
        end
        default:
        begin
          // one code per sample period keeps the output step small
          if (tick)
          begin
            if (dac_code == MID_SCALE)
              play_state <= PLAY_IDLE;
            else
              dac_code <= ramp_next;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output stage control

  wire digital_power = force_on | (play_state != PLAY_IDLE);

  assign power_stage_enable   = ~standby & (mux ? force_on : digital_power);
  assign analog_source_select = mux;
  assign amp_gain             = gain;

endmodule

/* inc/hsf_pkg.sv */
package hsf_pkg;

  // serial bus identity and register map
  localparam logic [6:0] SLAVE_ADDR     = 7'h59;
  localparam logic [7:0] REG_STATUS     = 8'h00;
  localparam logic [7:0] REG_CTRL       = 8'h01;
  localparam logic [7:0] REG_POWER      = 8'h02;
  localparam logic [7:0] REG_SAMPLE     = 8'h0b;
  localparam logic [7:0] READ_ZERO      = 8'h00;

  // field positions
  localparam int STAT_FULL_BIT  = 0;
  localparam int STAT_EMPTY_BIT = 1;
  localparam int CTRL_GAIN_LSB  = 0;
  localparam int CTRL_MUX_BIT   = 2;
  localparam int PWR_FORCE_BIT  = 1;
  localparam int PWR_TMO_LSB    = 2;
  localparam int PWR_STBY_BIT   = 6;
  localparam int PWR_RST_BIT    = 7;
  localparam int BYTE_MSB       = 7;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // reset values
  localparam logic [1:0] GAIN_RST  = 2'h0;
  localparam logic       MUX_RST   = 1'b0;
  localparam logic       STBY_RST  = 1'b1;
  localparam logic [1:0] TMO_RST   = 2'h0;
  localparam logic       FORCE_RST = 1'b0;

  // sample format: two's complement, mid-scale is zero
  localparam int         SAMPLE_W    = 8;
  localparam int         QUEUE_DEPTH = 100;
  localparam logic [7:0] MID_SCALE   = 8'h00;
  localparam logic [7:0] RAMP_STEP   = 8'h01;

  // timing at the system clock
  localparam int CLK_HZ           = 10_000_000;
  localparam int SAMPLE_HZ        = 8_000;
  localparam int SAMPLE_CYCLES    = CLK_HZ / SAMPLE_HZ;
  localparam int WAKE_TIME_US     = 2_000;
  localparam int WAKE_CYCLES      = WAKE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int TMO_STEP_US      = 5_000;
  localparam int TMO_STEP_CYCLES  = TMO_STEP_US * (CLK_HZ / 1_000_000);

  typedef enum logic [2:0] {BUS_IDLE, BUS_DEV, BUS_REG, BUS_WRITE, BUS_READ} hsf_bus_t;
  typedef enum logic [1:0] {BIT_DATA, BIT_ACK_SETUP, BIT_ACK} hsf_bit_t;
  typedef enum logic [2:0] {PLAY_IDLE, PLAY_WAKE, PLAY_RUN, PLAY_WAIT, PLAY_RAMP} hsf_play_t;

endpackage

/* design/hsf_sample_queue.sv */
module hsf_sample_queue
  import hsf_pkg::*;
#(
  parameter int WIDTH = SAMPLE_W,
  parameter int DEPTH = QUEUE_DEPTH
)
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             flush,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  input  wire logic             pop,
  output logic                  full,
  output logic                  empty,
  output logic [WIDTH-1:0]      pop_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_idx;
  logic [AW-1:0]    rd_idx;
  logic [AW:0]      count;

  // a push into a full queue is dropped, never overwriting unplayed data
  wire do_push = push & ~full;
  wire do_pop  = pop & ~empty;
  wire [AW-1:0] next_wr = (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + AW'(1);
  wire [AW-1:0] next_rd = (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + AW'(1);

  assign full     = (count == (AW+1)'(DEPTH));
  assign empty    = (count == '0);
  assign pop_data = mem[rd_idx];

  always_ff @(posedge clk)
  begin
    if (do_push)
      mem[wr_idx] <= push_data;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_idx <= '0;
      rd_idx <= '0;
      count  <= '0;
    end
    else if (flush)
    begin
      wr_idx <= '0;
      rd_idx <= '0;
      count  <= '0;
    end
    else
    begin
      if (do_push)
        wr_idx <= next_wr;
      if (do_pop)
        rd_idx <= next_rd;
      if (do_push & ~do_pop)
        count <= count + (AW+1)'(1);
      else if (do_pop & ~do_push)
        count <= count - (AW+1)'(1);
    end
  end

endmodule

/* test/hsf_top_properties.sv */
module hsf_top_properties
  import hsf_pkg::*;
#(
  parameter int WAKE_CYC   = WAKE_CYCLES,
  parameter int SAMPLE_CYC = SAMPLE_CYCLES
)
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       scl,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic [7:0] dac_code,
  input wire logic       power_stage_enable,
  input wire logic       analog_source_select,
  input wire logic [1:0] amp_gain
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [15:0] dac_gap;
  logic [15:0] pow_age;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////
  // saturating ages, so the first change after reset never looks early
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dac_gap <= 16'hffff;
      pow_age <= 16'h0000;
    end
    else
    begin
      dac_gap <= $changed(dac_code) ? 16'h0000 : dac_gap + {15'h0, dac_gap != 16'hffff};
      pow_age <= !power_stage_enable ? 16'h0000 : pow_age + {15'h0, pow_age != 16'hffff};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  ack_rise_a: assert property ($rose(sda_oe) |-> !scl)
    else $error("data line pulled low while clock high");
  ack_hold_a: assert property (sda_oe && scl |=> sda_oe)
    else $error("acknowledge dropped during clock high");
  oe_release_a: assert property ($fell(sda_oe) |-> !scl && !$past(scl))
    else $error("data line released outside clock low");
  od_low_a: assert property (sda_oe |-> sda_out == 1'b0)
    else $error("open drain output not low while enabled");
  // margin of two cycles: the wake count and the power flag start a cycle apart
  dac_pace_a: assert property ($changed(dac_code) && dac_code != 8'h00 |-> dac_gap >= SAMPLE_CYC - 1)
    else $error("samples played faster than the sample rate");
  wake_delay_a: assert property ($changed(dac_code) && dac_code != 8'h00 && !analog_source_select
    |-> power_stage_enable && pow_age >= WAKE_CYC - 2)
    else $error("sample played before wake completed");
  power_idle_a: assert property ($fell(power_stage_enable) && !analog_source_select |-> dac_code == 8'h00)
    else $error("power dropped with output away from mid-scale");
  idle_hold_a: assert property (!power_stage_enable && !$past(power_stage_enable) |-> $stable(dac_code))
    else $error("output moved while powered down");

  cover property ($rose(sda_oe));
  cover property ($changed(dac_code) && dac_code == 8'h80);
  cover property (analog_source_select && amp_gain == 2'h3 && power_stage_enable);
endmodule

/* test/hsf_host_model.sv */
module hsf_host_model
(
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_drv
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // clock low lasts 3 cycles and clock high 4 so the slave sees every edge
  task automatic bit_io(input logic b, output logic r);
    @(posedge clk) sda_drv <= b;
    repeat (2) @(posedge clk);
    scl <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk) r = sda_line;
    @(posedge clk) scl <= 1'b0;
  endtask

  task automatic start_c;
    @(posedge clk) sda_drv <= 1'b1;
    repeat (2) @(posedge clk);
    scl <= 1'b1;
    repeat (3) @(posedge clk);
    sda_drv <= 1'b0;
    repeat (3) @(posedge clk);
    scl <= 1'b0;
  endtask

  task automatic stop_c;
    @(posedge clk) sda_drv <= 1'b0;
    repeat (2) @(posedge clk);
    scl <= 1'b1;
    repeat (3) @(posedge clk);
    sda_drv <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // released line in the ninth clock reads the slave's answer
  task automatic put_byte(input logic [7:0] d, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    a = !r;
  endtask

  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule

/* test/haptic_sample_fifo_i2c_bench.sv */
module haptic_sample_fifo_i2c_bench
  import hsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int         WAKE  = 2000;
  localparam int         SAMP  = 1000;
  localparam int         TSTEP = 500;
  localparam int         DEP   = 4;
  localparam logic [3:0] CID   = 4'ha; // arbitrary value
  localparam logic [7:0] CTRL0 = {1'b0, CID, 3'h0};

  logic       clk;
  logic       rst;
  logic       scl;
  logic       sda_drv;
  logic       sda_out;
  logic       sda_oe;
  logic       pwr;
  logic       asel;
  logic [7:0] dac;
  logic [1:0] gain;
  logic [7:0] v;
  wire        sda_line;
  int         fails;
  int         checked;

  // wired-AND with pull-up: released line reads high
  assign sda_line = sda_drv & ~(sda_oe & ~sda_out);

  hsf_top #(.WAKE_CYC(WAKE), .TMO_STEP_CYC(TSTEP), .SAMPLE_CYC(SAMP), .DEPTH(DEP), .CHIP_ID(CID)) uut (
    .clk(clk), .rst(rst), .scl(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .dac_code(dac), .power_stage_enable(pwr), .analog_source_select(asel), .amp_gain(gain));

  hsf_host_model host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict;
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] r, input logic [7:0] d[$], input logic e[$]);
    logic a;
    host.start_c;
    host.put_byte({SLAVE_ADDR, 1'b0}, a);
    check("wr_addr_ack", {7'h0, a}, 8'h01);
    host.put_byte(r, a);
    check("wr_reg_ack", {7'h0, a}, 8'h01);
    foreach (d[i])
    begin
      host.put_byte(d[i], a);
      check("wr_data_ack", {7'h0, a}, {7'h0, e[i]});
    end
    host.stop_c;
  endtask

  task automatic rd(input logic [7:0] r, input logic [7:0] e[$]);
    logic       a;
    logic [7:0] d;
    host.start_c;
    host.put_byte({SLAVE_ADDR, 1'b0}, a);
    host.put_byte(r, a);
    host.start_c;
    host.put_byte({SLAVE_ADDR, 1'b1}, a);
    check("rd_addr_ack", {7'h0, a}, 8'h01);
    foreach (e[i])
    begin
      host.get_byte(i == e.size() - 1, d);
      check("rd_data", d, e[i]);
    end
    host.stop_c;
  endtask

  // bounded wait for the next output change
  task automatic wait_dac(input int n, output logic [7:0] q);
    logic [7:0] p;
    p = dac;
    for (int k = 0; k < n && dac === p; k++)
      @(negedge clk);
    q = dac;
    if (dac === p)
    begin
      check("dac_timeout", 8'h00, 8'h01);
      print_verdict();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    logic a;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    check("dac_rst", dac, MID_SCALE);
    check("pwr_rst", {7'h0, pwr}, 8'h00);
    rd(REG_STATUS, '{8'h02, CTRL0, 8'h40});
    rd(REG_SAMPLE, '{8'h00});
    host.start_c;
    host.put_byte(8'ha0, a);
    check("bad_addr_ack", {7'h0, a}, 8'h00);
    host.stop_c;
    wr(REG_POWER, '{8'h00}, '{1'b1});
    // depth 4: fifth and sixth bytes refused, address stays at the entry
    wr(REG_SAMPLE, '{8'h7f, 8'h80, 8'h01, 8'h22, 8'h02, 8'h09}, '{1, 1, 1, 1, 0, 0});
    rd(REG_STATUS, '{8'h01});
    check("dac_waking", dac, MID_SCALE);
    check("pwr_waking", {7'h0, pwr}, 8'h01);
    wait_dac(3 * WAKE, v);
    check("dac_first", v, 8'h7f);
    // resent byte is near mid-scale, so the waveform ends without a step
    wr(REG_SAMPLE, '{8'h02}, '{1'b1});
    for (int i = 3; i >= 0; i--)
    begin
      wait_dac(SAMP + 50, v);
      check("dac_play", v, i == 3 ? 8'h80 : i == 2 ? 8'h01 : i == 1 ? 8'h22 : 8'h02);
    end
    wait_dac((TMO_RST + 1) * TSTEP + 2 * SAMP, v);
    check("dac_ramp", v, 8'h01);
    wr(REG_SAMPLE, '{8'h30}, '{1'b1});
    wait_dac(SAMP + 50, v);
    check("dac_ramp_end", v, MID_SCALE);
    // idle lands on the tick one sample period later; look once it has settled
    repeat (SAMP + 2) @(negedge clk);
    check("dac_idle", dac, MID_SCALE);
    check("pwr_idle", {7'h0, pwr}, 8'h00);
    rd(REG_STATUS, '{8'h02});
    wr(REG_CTRL, '{8'h07}, '{1'b1});
    check("src_sel", {7'h0, asel}, 8'h01);
    check("gain", {6'h0, gain}, 8'h03);
    check("pwr_analog", {7'h0, pwr}, 8'h00);
    wr(REG_POWER, '{8'h02}, '{1'b1});
    check("pwr_force", {7'h0, pwr}, 8'h01);
    wr(REG_POWER, '{8'h00}, '{1'b1});
    check("pwr_unforce", {7'h0, pwr}, 8'h00);
    wr(REG_POWER, '{8'h80}, '{1'b1});
    rd(REG_CTRL, '{CTRL0, 8'h40});
    check("src_sel_rst", {6'h0, asel, gain[1]}, 8'h00);
    print_verdict();
  end
endmodule

bind hsf_top hsf_top_properties #(.WAKE_CYC(WAKE_CYC), .SAMPLE_CYC(SAMPLE_CYC)) u_props (
  .clk(clk), .rst(rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .dac_code(dac_code), .power_stage_enable(power_stage_enable),
  .analog_source_select(analog_source_select), .amp_gain(amp_gain));
